// ### verilog/sshl_defines.svh
`ifndef SSHL_DEFINES_SVH
`define SSHL_DEFINES_SVH

`define SSHL_WORD_BITS 32
`define SSHL_BIT_W 5
`define SSHL_LAST_BIT 5'h1f
`define SSHL_PAY_W 8
`define SSHL_WCNT_W 9
`define SSHL_DIV_W 8
`define SSHL_LAT_W 3
`define SSHL_HDR_WORDS 9'h001
`define SSHL_MISO_LAT 3'h5
`define SSHL_CLK_HZ 20000000
`define SSHL_SCLK_MAX_HZ 20000000
`define SSHL_DIV_HALF_MIN \
  ((`SSHL_CLK_HZ + 2 * `SSHL_SCLK_MAX_HZ - 1) / (2 * `SSHL_SCLK_MAX_HZ))
`define SSHL_DIV_HALF_SAFE 3
`define SSHL_DIV_HALF_DEF 8'h04

`endif

// ### verilog/sshl_pkg.sv
`include "sshl_defines.svh"

package sshl_pkg;

  typedef enum logic [2:0]
  {
    SSHL_IDLE = 3'h0,
    SSHL_WAIT = 3'h1,
    SSHL_RUN = 3'h3,
    SSHL_TAIL = 3'h2,
    SSHL_GAP = 3'h6
  } sshl_state_e;

  typedef struct packed
  {
    sshl_state_e st;
    logic [2:0] srdy_sy;
    logic srdy_f;
    logic srdy_prev;
    logic [2:0] miso_sy;
    logic miso_f;
    logic [`SSHL_DIV_W-1:0] div;
    logic sclk;
    logic mosi;
    logic mrdy;
    logic keep;
    logic [`SSHL_WORD_BITS-1:0] tx_sh;
    logic [`SSHL_BIT_W-1:0] tx_bit;
    logic [`SSHL_BIT_W-1:0] fall_bit;
    logic [`SSHL_WCNT_W-1:0] fall_word;
    logic [`SSHL_WCNT_W-1:0] total;
    logic [`SSHL_LAT_W-1:0] cap;
    logic [`SSHL_WORD_BITS-1:0] rx_sh;
    logic [`SSHL_BIT_W-1:0] rx_bit;
    logic [`SSHL_WCNT_W-1:0] rx_words;
    logic [`SSHL_WORD_BITS-1:0] rx_word;
    logic rx_valid;
    logic done;
    logic wake;
  } sshl_state_s;

endpackage

// ### verilog/sshl_master.sv
`timescale 1ns/1ns
`include "sshl_defines.svh"

module sshl_master
#(
  parameter logic [`SSHL_DIV_W-1:0] DIV_HALF = `SSHL_DIV_HALF_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [`SSHL_PAY_W-1:0] pay_words,
  input wire logic keep_ready,
  input wire logic [`SSHL_WORD_BITS-1:0] tx_word,
  output logic tx_take,
  output logic [`SSHL_WORD_BITS-1:0] rx_word,
  output logic rx_valid,
  output logic frame_done,
  output logic busy,
  output logic slave_pending,
  output logic slave_wake,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  output logic master_ready,
  input wire logic slave_ready
);

  localparam logic [`SSHL_WCNT_W-1:0] ONE_W = `SSHL_WCNT_W'(1);

  sshl_pkg::sshl_state_s state_r;
  sshl_pkg::sshl_state_s state_nxt;

  logic wrap;
  logic rise;
  logic fall;

  // Glitch filter behind a three-stage synchroniser
  function automatic logic filt(input logic [2:0] sy, input logic f);
    filt = (sy[1] == sy[2]) ? sy[2] : f;
  endfunction

  function automatic logic last_fall(input logic [`SSHL_WCNT_W-1:0] word,
                                     input logic [`SSHL_BIT_W-1:0] bit_i,
                                     input logic [`SSHL_WCNT_W-1:0] total);
    last_fall = (word == total - ONE_W) && (bit_i == `SSHL_LAST_BIT);
  endfunction

  assign wrap = (state_r.div == DIV_HALF - `SSHL_DIV_W'(1));
  assign rise = (state_r.st == sshl_pkg::SSHL_RUN) && wrap && !state_r.sclk;
  assign fall = (state_r.st == sshl_pkg::SSHL_RUN) && wrap && state_r.sclk;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.srdy_sy = {state_r.srdy_sy[1:0], slave_ready};
    state_nxt.srdy_f = filt(state_r.srdy_sy, state_r.srdy_f);
    state_nxt.srdy_prev = state_r.srdy_f;
    state_nxt.miso_sy = {state_r.miso_sy[1:0], miso};
    state_nxt.miso_f = filt(state_r.miso_sy, state_r.miso_f);
    // Rising slave ready while idle is the device's wake request
    state_nxt.wake = state_r.srdy_f && !state_r.srdy_prev
                     && (state_r.st == sshl_pkg::SSHL_IDLE);
    state_nxt.rx_valid = 1'b0;
    state_nxt.done = 1'b0;

    // Miso is read late by the synchroniser depth; slave holds it a full period
    if (state_r.cap != `SSHL_LAT_W'(0))
    begin
      state_nxt.cap = state_r.cap - `SSHL_LAT_W'(1);
      if (state_r.cap == `SSHL_LAT_W'(1))
      begin
        state_nxt.rx_sh = {state_r.rx_sh[`SSHL_WORD_BITS-2:0], state_r.miso_f};
        state_nxt.rx_bit = state_r.rx_bit + `SSHL_BIT_W'(1);
        if (state_r.rx_bit == `SSHL_LAST_BIT)
        begin
          state_nxt.rx_word = {state_r.rx_sh[`SSHL_WORD_BITS-2:0], state_r.miso_f};
          state_nxt.rx_valid = 1'b1;
          state_nxt.rx_words = state_r.rx_words + ONE_W;
        end
      end
    end

    case (state_r.st)
      sshl_pkg::SSHL_IDLE:
      begin
        state_nxt.mosi = 1'b1;
        state_nxt.sclk = 1'b0;
        state_nxt.div = `SSHL_DIV_W'(0);
        if (start)
        begin
          // Raising master ready also wakes a sleeping device
          state_nxt.mrdy = 1'b1;
          state_nxt.keep = keep_ready;
          state_nxt.total = `SSHL_HDR_WORDS + `SSHL_WCNT_W'(pay_words);
          state_nxt.tx_bit = `SSHL_BIT_W'(0);
          state_nxt.fall_bit = `SSHL_BIT_W'(0);
          state_nxt.fall_word = `SSHL_WCNT_W'(0);
          state_nxt.rx_bit = `SSHL_BIT_W'(0);
          state_nxt.rx_words = `SSHL_WCNT_W'(0);
          state_nxt.cap = `SSHL_LAT_W'(0);
          state_nxt.st = sshl_pkg::SSHL_WAIT;
        end
        else if (!state_r.keep)
        begin
          state_nxt.mrdy = 1'b0;
        end
      end
      sshl_pkg::SSHL_WAIT:
      begin
        // No clock until the device has announced readiness
        if (state_r.srdy_f)
        begin
          state_nxt.st = sshl_pkg::SSHL_RUN;
          state_nxt.div = `SSHL_DIV_W'(0);
        end
      end
      sshl_pkg::SSHL_RUN:
      begin
        state_nxt.div = wrap ? `SSHL_DIV_W'(0) : state_r.div + `SSHL_DIV_W'(1);
        if (wrap)
        begin
          state_nxt.sclk = !state_r.sclk;
        end
        if (rise)
        begin
          if (state_r.tx_bit == `SSHL_BIT_W'(0))
          begin
            state_nxt.mosi = tx_word[`SSHL_WORD_BITS-1];
            state_nxt.tx_sh = {tx_word[`SSHL_WORD_BITS-2:0], 1'b1};
          end
          else
          begin
            state_nxt.mosi = state_r.tx_sh[`SSHL_WORD_BITS-1];
            state_nxt.tx_sh = {state_r.tx_sh[`SSHL_WORD_BITS-2:0], 1'b1};
          end
          state_nxt.tx_bit = state_r.tx_bit + `SSHL_BIT_W'(1);
        end
        if (fall)
        begin
          state_nxt.cap = `SSHL_MISO_LAT;
          state_nxt.fall_bit = state_r.fall_bit + `SSHL_BIT_W'(1);
          if (state_r.fall_bit == `SSHL_LAST_BIT)
          begin
            state_nxt.fall_word = state_r.fall_word + ONE_W;
          end
          if (last_fall(state_r.fall_word, state_r.fall_bit, state_r.total))
          begin
            state_nxt.st = sshl_pkg::SSHL_TAIL;
          end
        end
      end
      sshl_pkg::SSHL_TAIL:
      begin
        if (state_r.rx_words == state_r.total)
        begin
          state_nxt.mosi = 1'b1;
          state_nxt.mrdy = state_r.keep;
          state_nxt.done = 1'b1;
          state_nxt.st = sshl_pkg::SSHL_GAP;
        end
      end
      sshl_pkg::SSHL_GAP:
      begin
        // Slave ready must fall before a new frame; a quick reassertion is then seen
        if (!state_r.srdy_f)
        begin
          state_nxt.st = sshl_pkg::SSHL_IDLE;
        end
      end
      default:
      begin
        state_nxt.st = sshl_pkg::SSHL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= '0;
      state_r.st <= sshl_pkg::SSHL_IDLE;
      state_r.mosi <= 1'b1;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  assign tx_take = ce && rise && (state_r.tx_bit == `SSHL_BIT_W'(0));
  assign rx_word = state_r.rx_word;
  assign rx_valid = state_r.rx_valid;
  assign frame_done = state_r.done;
  assign busy = (state_r.st != sshl_pkg::SSHL_IDLE);
  assign slave_pending = state_r.srdy_f;
  assign slave_wake = state_r.wake;
  assign sclk = state_r.sclk;
  assign mosi = state_r.mosi;
  assign master_ready = state_r.mrdy;

  // Helper: serial clock rising edges in the current frame
  logic [`SSHL_WCNT_W+`SSHL_BIT_W-1:0] rise_cnt_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rise_cnt_r <= '0;
    end
    else if (ce && start && !busy)
    begin
      rise_cnt_r <= '0;
    end
    else if (ce && rise)
    begin
      rise_cnt_r <= rise_cnt_r + (`SSHL_WCNT_W + `SSHL_BIT_W)'(1);
    end
  end

  chk_div_legal: assert property (@(posedge clk) disable iff (rst)
    DIV_HALF >= `SSHL_DIV_HALF_MIN && DIV_HALF >= `SSHL_DIV_HALF_SAFE)
    else $error("serial clock divider too small");

  chk_sclk_idle_low: assert property (@(posedge clk) disable iff (rst)
    state_r.st != sshl_pkg::SSHL_RUN |-> !sclk)
    else $error("serial clock not low outside a burst");

  chk_mosi_idle_high: assert property (@(posedge clk) disable iff (rst)
    (state_r.st == sshl_pkg::SSHL_IDLE || state_r.st == sshl_pkg::SSHL_GAP) |-> mosi)
    else $error("data line not idle high");

  chk_start_both_ready: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r.st == sshl_pkg::SSHL_RUN) |-> master_ready && state_r.srdy_f)
    else $error("burst started without both ready lines");

  chk_clock_count: assert property (@(posedge clk) disable iff (rst)
    frame_done |-> rise_cnt_r == {state_r.total, 5'h00})
    else $error("wrong number of serial clocks");

  chk_rx_words: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r.st == sshl_pkg::SSHL_GAP) |-> state_r.rx_words == state_r.total)
    else $error("received word count differs from sent");

  chk_mrdy_after: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r.st == sshl_pkg::SSHL_GAP) |-> master_ready == state_r.keep)
    else $error("master ready wrong after burst");

  chk_gap_waits: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_GAP && state_r.srdy_f
    |=> state_r.st == sshl_pkg::SSHL_GAP)
    else $error("left gap before slave ready fell");

  chk_wake_event: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.srdy_f && !state_r.srdy_prev && state_r.st == sshl_pkg::SSHL_IDLE
    |=> slave_wake)
    else $error("slave ready rise not flagged");

  chk_run_mrdy: assert property (@(posedge clk) disable iff (rst)
    state_r.st == sshl_pkg::SSHL_RUN |-> master_ready)
    else $error("clocking without master ready");

  cov_frame: cover property (@(posedge clk) disable iff (rst) frame_done);
  cov_keep: cover property (@(posedge clk) disable iff (rst) frame_done && state_r.keep);
  cov_wake: cover property (@(posedge clk) disable iff (rst) slave_wake);
  cov_freeze: cover property (@(posedge clk) disable iff (rst) !ce && start);
  cov_long: cover property (@(posedge clk) disable iff (rst) frame_done && state_r.total > 9'h008);

  // Helper: enabled cycles since the serial clock last changed
  logic [`SSHL_DIV_W-1:0] half_cnt_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      half_cnt_r <= '0;
    end
    else if (ce && (state_r.st != sshl_pkg::SSHL_RUN || wrap))
    begin
      half_cnt_r <= '0;
    end
    else if (ce)
    begin
      half_cnt_r <= half_cnt_r + `SSHL_DIV_W'(1);
    end
  end

  // Half period never stretches beyond DIV_HALF enabled cycles
  chk_half_bound: assert property (@(posedge clk) disable iff (rst)
    state_r.st == sshl_pkg::SSHL_RUN |-> half_cnt_r < DIV_HALF)
    else $error("serial clock half period too long");

  chk_half_exact: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_RUN && wrap |-> half_cnt_r == DIV_HALF - `SSHL_DIV_W'(1))
    else $error("serial clock half period wrong");

  chk_freeze_state: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(state_r))
    else $error("state moved while clock enable low");

  chk_mrdy_idle_low: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_IDLE && !state_r.keep && !start |=> !master_ready)
    else $error("master ready not low while idle");

  chk_keep_holds: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_IDLE && state_r.keep && master_ready |=> master_ready)
    else $error("master ready dropped during multi-packet run");

  chk_mosi_hold: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_RUN && !rise |=> $stable(mosi))
    else $error("data line changed away from a rising edge");

  chk_take_msb: assert property (@(posedge clk) disable iff (rst)
    tx_take |=> mosi == $past(tx_word[`SSHL_WORD_BITS-1]))
    else $error("first bit is not the word's top bit");

  chk_wait_srdy: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_WAIT && !state_r.srdy_f
    |=> state_r.st == sshl_pkg::SSHL_WAIT)
    else $error("left wait without slave ready");

  chk_run_from_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r.st == sshl_pkg::SSHL_RUN) |-> $past(state_r.st) == sshl_pkg::SSHL_WAIT)
    else $error("burst entered from wrong state");

  chk_done_pulse: assert property (@(posedge clk) disable iff (rst)
    ce && frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");

  chk_start_mrdy: assert property (@(posedge clk) disable iff (rst)
    ce && start && !busy |=> master_ready && busy)
    else $error("start did not raise master ready");

  chk_sclk_toggle: assert property (@(posedge clk) disable iff (rst)
    ce && state_r.st == sshl_pkg::SSHL_RUN && wrap |=> sclk != $past(sclk))
    else $error("serial clock did not toggle");

  chk_wake_idle: assert property (@(posedge clk) disable iff (rst)
    slave_wake |-> $past(state_r.st) == sshl_pkg::SSHL_IDLE)
    else $error("wake flagged outside idle");

  chk_done_busy: assert property (@(posedge clk) disable iff (rst)
    frame_done |-> busy)
    else $error("idle at frame end");

  chk_rx_in_frame: assert property (@(posedge clk) disable iff (rst)
    rx_valid |-> state_r.st == sshl_pkg::SSHL_RUN || state_r.st == sshl_pkg::SSHL_TAIL)
    else $error("word received outside a frame");

endmodule

// ### tb/sshl_dev_model.sv
`timescale 1ns/1ns

module sshl_dev_model
#(
  parameter logic [31:0] DEV_BASE = 32'hc5a0_0f00
)
(
  input wire logic clk,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  input wire logic master_ready,
  output logic slave_ready,
  input wire logic [8:0] words,
  input wire logic initiate,
  input wire logic [7:0] lag
);
  logic [31:0] rx_mem [0:15];
  logic [31:0] rx_sh;
  logic [31:0] w;
  int rc;
  int fc;

  // Slave only: it never clocks, it answers the master's bursts
  initial
  begin
    slave_ready = 1'b0;
    miso = 1'b1;
    rc = 0;
    fc = 0;
    forever
    begin
      wait (master_ready || initiate);
      repeat (lag) @(posedge clk);
      rc = 0;
      fc = 0;
      slave_ready = 1'b1;
      wait (fc == 32 * int'(words));
      repeat (3) @(posedge clk);
      slave_ready = 1'b0;
      miso = 1'b1;
      // Gap stands for the device processing the frame
      repeat (20) @(posedge clk);
    end
  end

  always @(posedge sclk)
  begin
    w = DEV_BASE + 32'(rc / 32);
    miso = w[31 - (rc % 32)];
    rc = rc + 1;
  end

  always @(negedge sclk)
  begin
    rx_sh = {rx_sh[30:0], mosi};
    fc = fc + 1;
    if (fc % 32 == 0 && fc <= 512)
      rx_mem[fc / 32 - 1] = rx_sh;
  end
endmodule

// ### tb/sshl_master_tb.sv
`timescale 1ns/1ns

module sshl_master_tb;
  localparam logic [31:0] TXB = 32'h3c00_0100;
  localparam logic [31:0] DEVB = 32'hc5a0_0f00;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic [7:0] pay_words = 8'h00;
  logic keep_ready = 1'b0;
  logic [31:0] tx_word;
  logic tx_take, rx_valid, frame_done, busy, slave_pending, slave_wake;
  logic sclk, mosi, miso, master_ready, slave_ready;
  logic [31:0] rx_word;
  logic [8:0] words = 9'h001;
  logic initiate = 1'b0;
  logic [7:0] lag = 8'h02;
  logic [31:0] got [0:15];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tk = 0;
  int rk = 0;

  always #25 clk = ~clk;
  assign tx_word = TXB + 32'(tk);

  sshl_master #(.DIV_HALF(8'h03)) sshl_master_i (.clk(clk), .rst(rst), .ce(ce), .start(start),
    .pay_words(pay_words), .keep_ready(keep_ready), .tx_word(tx_word), .tx_take(tx_take),
    .rx_word(rx_word), .rx_valid(rx_valid), .frame_done(frame_done), .busy(busy),
    .slave_pending(slave_pending), .slave_wake(slave_wake), .sclk(sclk), .mosi(mosi),
    .miso(miso), .master_ready(master_ready), .slave_ready(slave_ready));

  sshl_dev_model #(.DEV_BASE(DEVB)) sshl_dev_model_i (.clk(clk), .sclk(sclk), .mosi(mosi),
    .miso(miso), .master_ready(master_ready), .slave_ready(slave_ready), .words(words),
    .initiate(initiate), .lag(lag));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic stop_test;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (rx_valid === 1'b1)
    begin
      got[rk] <= rx_word;
      rk <= rk + 1;
    end
    if (tx_take === 1'b1)
      tk <= tk + 1;
    if (cyc == 60000)
    begin
      fails++;
      stop_test;
    end
  end

  // Any rising clock edge without both ready lines up is a fault
  always @(posedge sclk)
    chk({30'h0, master_ready, slave_ready}, 32'h3);

  task automatic run_frame(input logic [7:0] pay, input logic keep, input int hold);
    int n;
    words <= 9'(pay) + 9'h001;
    tk <= 0;
    rk <= 0;
    pay_words <= pay;
    keep_ready <= keep;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (hold) @(posedge clk);
    if (hold > 0)
      chk({31'h0, sclk}, 32'h0);
    n = 0;
    while (frame_done !== 1'b1 && n < 8000)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i <= int'(pay); i++)
    begin
      chk(got[i], DEVB + 32'(i));
      chk(sshl_dev_model_i.rx_mem[i], TXB + 32'(i));
    end
    chk(32'(rk), 32'(pay) + 32'h1);
    chk(32'(sshl_dev_model_i.rc), 32'h20 * (32'(pay) + 32'h1));
    chk({30'h0, sclk, mosi}, 32'h1);
    chk({31'h0, master_ready}, {31'h0, keep});
  endtask

  task automatic t_idle;
    chk({28'h0, sclk, mosi, master_ready, busy}, 32'h4);
    $display("test idle done");
  endtask

  task automatic t_master;
    run_frame(8'h00, 1'b0, 0);
    run_frame(8'h0f, 1'b0, 0);
    $display("test master done");
  endtask

  task automatic t_multi;
    run_frame(8'h02, 1'b1, 0);
    run_frame(8'h01, 1'b0, 0);
    $display("test multi done");
  endtask

  task automatic t_slave_init;
    int n;
    initiate <= 1'b1;
    n = 0;
    while (slave_wake !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk({30'h0, slave_wake, master_ready}, 32'h2);
    chk({31'h0, slave_pending}, 32'h1);
    initiate <= 1'b0;
    run_frame(8'h01, 1'b0, 0);
    $display("test slave_init done");
  endtask

  task automatic t_freeze;
    ce <= 1'b0;
    start <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, busy, master_ready}, 32'h0);
    start <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk({30'h0, busy, master_ready}, 32'h0);
    $display("test freeze done");
  endtask

  task automatic t_slow;
    lag <= 8'h3c;
    run_frame(8'h00, 1'b0, 40);
    lag <= 8'h02;
    $display("test slow done");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_idle;
    t_freeze;
    t_master;
    t_multi;
    t_slave_init;
    t_slow;
    stop_test;
  end
endmodule
